// ===== pkg/cfg_pkg.sv
// Package for the output configuration register block.
// Assumes a 20 MHz core clock and a register port decoded upstream by the serial front end.
package cfg_pkg;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [6:0] GEN_CFG_ADDR = 7'h03;
	localparam logic [15:0] GEN_CFG_RESET = 16'h0001;
	localparam logic [15:0] GEN_CFG_WMASK = 16'hFDFF;
	localparam int LATCH_HI = 15;
	localparam int LATCH_LO = 12;
	localparam int EDGE_HI = 11;
	localparam int EDGE_LO = 10;
	localparam int REF_BIT = 8;
	localparam int PERIOD_HI = 7;
	localparam int PERIOD_LO = 4;
	localparam int ACTION_BIT = 3;
	localparam int WDOG_ON_BIT = 2;
	localparam int POLICY_BIT = 1;
	localparam int CRC_BIT = 0;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam longint CLK_HZ = 20000000;
	localparam longint STEP_MS = 100;
	localparam longint STEP_CYC = CLK_HZ * STEP_MS / 1000;
	localparam longint RETRY_PERIOD_MS = 8;
	localparam longint RETRY_CYC = CLK_HZ * RETRY_PERIOD_MS / 1000;
	localparam longint RETRY_ON_US = 400;
	localparam longint RETRY_ON_CYC = CLK_HZ * RETRY_ON_US / 1000000;
	localparam int FRAME_CRC_BITS = 32;
	localparam int FRAME_PLAIN_BITS = 24;

	typedef enum logic [1:0] {
		EDGE_OFF = 2'b00,
		EDGE_RISE = 2'b01,
		EDGE_FALL = 2'b10,
		EDGE_LIVE = 2'b11
	} edge_mode_t;

	typedef struct packed {
		logic [3:0] latch_bypass;
		edge_mode_t comparator_edge_select;
		logic resv;
		logic ext_ref;
		logic [3:0] watchdog_period;
		logic watchdog_action;
		logic watchdog_on;
		logic overcurrent_policy;
		logic crc_on;
	} cfg_t;
endpackage

// ===== hdl/cfg_regs.sv
// Configuration register, inactivity watchdog and overcurrent recovery for four output channels.
// Assumes the serial front end presents decoded register accesses and a frame-end strobe.
// Function
// - Latch bypass bit zero keeps latch loaded
// - Latch bypass one makes latch transparent
// - Edge field selects comparator mode
// - Bit eight selects external reference
// - Period field gives (code+1)*100 ms
// - Action zero: watchdog only sets flag
// - Action one: flag and selective reset
// - Watchdog off never detects timeout
// - Auto policy: power down, retry periodically
// - Fault gone in retry keeps amplifier on
// - Host policy clears channel power bit
// - CRC enable bit resets to one
// - Frames 32 bits with CRC, 24 without
// - Watchdog flag set, cleared on read
// - Load strobe acts only when latch held
// - Power bits turn channels on or off
// - Interrupt low when flag and unmask
`timescale 1ns/1ns
`default_nettype none
module cfg_regs #(
	parameter int STEP_CYCLES = int'(cfg_pkg::STEP_CYC),
	parameter int RETRY_CYCLES = int'(cfg_pkg::RETRY_CYC),
	parameter int RETRY_ON_CYCLES = int'(cfg_pkg::RETRY_ON_CYC)
) (
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic CE,
	input wire logic WR_EN,
	input wire logic RD_EN,
	input wire logic [6:0] ADDR,
	input wire logic [15:0] WDATA,
	input wire logic FRAME_END,
	input wire logic [5:0] FRAME_BITS,
	input wire logic WATCHDOG_FLAG_READ,
	input wire logic WATCHDOG_FLAG_UNMASK,
	input wire logic [3:0] DAC_LOAD_STROBE,
	input wire logic LOAD_PIN,
	input wire logic [3:0] CHANNEL_POWER_WR,
	input wire logic CHANNEL_POWER_WE,
	input wire logic [3:0] OVERCURRENT_DET,
	output logic [15:0] RDATA,
	output logic [3:0] LATCH_TRANSPARENT,
	output logic [3:0] LATCH_LOAD,
	output logic [1:0] COMPARATOR_EDGE_SELECT,
	output logic EXT_REF,
	output logic CRC_ON,
	output logic FRAME_LEN32,
	output logic WATCHDOG_FLAG,
	output logic DEVICE_RESET,
	output logic INT_N,
	output logic [3:0] CHANNEL_POWER,
	output logic [3:0] AMP_ON,
	output logic [3:0] OVERCURRENT_FLAG
);
	// ----------------------------------------
	// Decode
	// ----------------------------------------
	cfg_pkg::cfg_t cfg_q;
	logic [15:0] cfg_bits;
	logic [15:0] cfg_d;
	logic [3:0] pwr_q;
	logic [3:0] pwr_d;
	logic [3:0] retry_q;
	logic [3:0] retry_d;
	logic [3:0] ovc_q;
	logic [3:0] ovc_d;
	logic [3:0] amp_d;
	logic [3:0] load_d;
	logic [31:0] wd_cnt_q;
	logic [3:0] wd_steps_q;
	logic flag_q;
	logic flag_d;
	logic [31:0] rt_cnt_q;
	logic wd_restart;
	logic wd_expire;
	logic step_done;
	logic frame_ok;
	logic cfg_wr;
	logic cfg_rd;
	logic wd_setting_wr;
	logic retry_on;
	logic dev_rst_d;
	logic [15:0] cfg_nx;

	assign cfg_bits = cfg_q;
	assign cfg_wr = WR_EN && ADDR == cfg_pkg::GEN_CFG_ADDR;
	assign cfg_rd = RD_EN && ADDR == cfg_pkg::GEN_CFG_ADDR;
	// Reserved bit holds zero since the mask never lets it in
	assign cfg_d = cfg_wr ? (WDATA & cfg_pkg::GEN_CFG_WMASK) : cfg_bits;
	assign wd_setting_wr = cfg_wr && (WDATA[cfg_pkg::PERIOD_HI:cfg_pkg::PERIOD_LO] != cfg_q.watchdog_period ||
		WDATA[cfg_pkg::WDOG_ON_BIT] != cfg_q.watchdog_on);
	// Short frames do not count as activity
	assign frame_ok = FRAME_END && (cfg_q.crc_on ? FRAME_BITS >= 6'(cfg_pkg::FRAME_CRC_BITS) :
		FRAME_BITS >= 6'(cfg_pkg::FRAME_PLAIN_BITS));
	assign wd_restart = frame_ok || wd_setting_wr || !cfg_q.watchdog_on;
	assign step_done = wd_cnt_q == 32'(STEP_CYCLES - 1);
	assign wd_expire = cfg_q.watchdog_on && step_done && wd_steps_q == cfg_q.watchdog_period
		&& !wd_restart;
	// Set wins over clear-on-read
	assign flag_d = wd_expire || (flag_q && !cfg_rd && !WATCHDOG_FLAG_READ);
	assign retry_on = rt_cnt_q < 32'(RETRY_ON_CYCLES);
	// Host policy clears power; a host write sets power even while a fault is present
	assign pwr_d = CHANNEL_POWER_WE ? CHANNEL_POWER_WR :
		(cfg_q.overcurrent_policy ? pwr_q & ~OVERCURRENT_DET : pwr_q);
	// Auto policy: retry while fault seen during a retry window, leave once it clears
	assign retry_d = cfg_q.overcurrent_policy ? 4'h0 :
		((retry_q | OVERCURRENT_DET) & ~(retry_q & {4{retry_on}} & ~OVERCURRENT_DET));
	assign ovc_d = ovc_q | OVERCURRENT_DET;
	// A channel in retry is powered for the window even though the fault is still seen
	assign amp_d = pwr_d & ~(OVERCURRENT_DET & ~(retry_q & {4{retry_on}})) &
		~(retry_d & {4{!retry_on}});
	// Software load counts only when the latch is held
	assign load_d = ~cfg_q.latch_bypass & (DAC_LOAD_STROBE | {4{LOAD_PIN}});
	// Outputs except LATCH_LOAD and RDATA follow the next state so a timeout reset never leaves them one cycle stale
	assign dev_rst_d = wd_expire && cfg_q.watchdog_action;
	assign cfg_nx = dev_rst_d ? ((cfg_pkg::GEN_CFG_RESET & ~16'h0101) | (cfg_bits & 16'h0101)) :
		cfg_d;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	// The timeout reset keeps reference, CRC and flag; unmask lives in the interrupt block
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			cfg_q <= cfg_pkg::cfg_t'(cfg_pkg::GEN_CFG_RESET);
			flag_q <= 1'b0;
		end else if (CE) begin
			flag_q <= flag_d;
			cfg_q <= cfg_pkg::cfg_t'(cfg_nx);
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			wd_cnt_q <= 32'h0000_0000;
			wd_steps_q <= 4'h0;
		end else if (CE) begin
			if (wd_restart || wd_expire) begin
				wd_cnt_q <= 32'h0000_0000;
				wd_steps_q <= 4'h0;
			end else if (step_done) begin
				wd_cnt_q <= 32'h0000_0000;
				wd_steps_q <= wd_steps_q + 4'h1;
			end else begin
				wd_cnt_q <= wd_cnt_q + 32'h0000_0001;
			end
		end
	end

	// Free running retry cadence shared by all channels; costs up to one period of latency
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			rt_cnt_q <= 32'h0000_0000;
		end else if (CE) begin
			rt_cnt_q <= (rt_cnt_q == 32'(RETRY_CYCLES - 1)) ? 32'h0000_0000 : rt_cnt_q + 32'h0000_0001;
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			pwr_q <= 4'h0;
			retry_q <= 4'h0;
			ovc_q <= 4'h0;
		end else if (CE) begin
			if (wd_expire && cfg_q.watchdog_action) begin
				pwr_q <= 4'h0;
				retry_q <= 4'h0;
				ovc_q <= 4'h0;
			end else begin
				pwr_q <= pwr_d;
				retry_q <= retry_d;
				ovc_q <= ovc_d;
			end
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			RDATA <= 16'h0000;
			LATCH_TRANSPARENT <= 4'h0;
			LATCH_LOAD <= 4'h0;
			COMPARATOR_EDGE_SELECT <= 2'b00;
			EXT_REF <= 1'b0;
			CRC_ON <= 1'b1;
			FRAME_LEN32 <= 1'b1;
			WATCHDOG_FLAG <= 1'b0;
			DEVICE_RESET <= 1'b0;
			INT_N <= 1'b1;
			CHANNEL_POWER <= 4'h0;
			AMP_ON <= 4'h0;
			OVERCURRENT_FLAG <= 4'h0;
		end else if (CE) begin
			RDATA <= cfg_rd ? cfg_bits : RDATA;
			LATCH_TRANSPARENT <= cfg_nx[cfg_pkg::LATCH_HI:cfg_pkg::LATCH_LO];
			LATCH_LOAD <= load_d;
			COMPARATOR_EDGE_SELECT <= cfg_nx[cfg_pkg::EDGE_HI:cfg_pkg::EDGE_LO];
			EXT_REF <= cfg_nx[cfg_pkg::REF_BIT];
			CRC_ON <= cfg_nx[cfg_pkg::CRC_BIT];
			FRAME_LEN32 <= cfg_nx[cfg_pkg::CRC_BIT];
			WATCHDOG_FLAG <= flag_d;
			DEVICE_RESET <= dev_rst_d;
			INT_N <= !(flag_d && WATCHDOG_FLAG_UNMASK);
			CHANNEL_POWER <= dev_rst_d ? 4'h0 : pwr_d;
			AMP_ON <= dev_rst_d ? 4'h0 : amp_d;
			OVERCURRENT_FLAG <= dev_rst_d ? 4'h0 : ovc_d;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RSTN);

	AST_RESV_ZERO: assert property (CE |=> cfg_bits[9] == 1'b0) else $error("reserved bit set");
	AST_WD_OFF: assert property (!cfg_q.watchdog_on |-> !wd_expire) else $error("timeout while off");
	AST_FLAG_SET: assert property (CE && wd_expire |=> flag_q) else $error("flag not set");
	AST_INT: assert property (CE && flag_d && WATCHDOG_FLAG_UNMASK |=> !INT_N) else $error("int not low");
	AST_NO_RESET: assert property (CE && wd_expire && !cfg_q.watchdog_action |=> !DEVICE_RESET)
		else $error("reset with action zero");
	AST_KEEP: assert property (CE && wd_expire && cfg_q.watchdog_action |=>
		cfg_q.crc_on == $past(cfg_q.crc_on) && cfg_q.ext_ref == $past(cfg_q.ext_ref) && DEVICE_RESET)
		else $error("kept bits lost");
	AST_HOST_OFF: assert property (CE && cfg_q.overcurrent_policy && OVERCURRENT_DET[0] && !CHANNEL_POWER_WE
		&& !(wd_expire && cfg_q.watchdog_action) |=> !pwr_q[0]) else $error("power not cleared");
	AST_LOAD: assert property (CE && cfg_q.latch_bypass[0] |=> !LATCH_LOAD[0]) else $error("load in bypass");
	AST_LEN: assert property (CE |=> FRAME_LEN32 == cfg_q.crc_on) else $error("frame length mismatch");
	AST_OVC_OFF: assert property (CE && OVERCURRENT_DET[1] && !(retry_q[1] && retry_on) |=> !AMP_ON[1])
		else $error("amp on in fault");

	// ----------------------------------------
	// Register and output tracking
	// ----------------------------------------
	AST_WRITE_LANDS: assert property (CE && cfg_wr && !dev_rst_d |=>
		cfg_bits == ($past(WDATA) & cfg_pkg::GEN_CFG_WMASK))
		else $error("write did not land");
	AST_TRANSP: assert property (CE |=> LATCH_TRANSPARENT == cfg_q.latch_bypass)
		else $error("latch bypass output stale");
	AST_EDGE: assert property (CE |=> COMPARATOR_EDGE_SELECT == cfg_q.comparator_edge_select)
		else $error("edge select output stale");
	AST_REF: assert property (CE |=> EXT_REF == cfg_q.ext_ref)
		else $error("reference output stale");
	AST_CRC: assert property (CE |=> CRC_ON == cfg_q.crc_on)
		else $error("crc output stale");
	AST_PWR: assert property (CE |=> CHANNEL_POWER == pwr_q)
		else $error("power output stale");

	// ----------------------------------------
	// Watchdog and retry
	// ----------------------------------------
	// Clear-on-read only when no new expiry races it
	AST_FLAG_CLEAR: assert property (CE && flag_q && (cfg_rd || WATCHDOG_FLAG_READ) && !wd_expire
		|=> !flag_q)
		else $error("flag not cleared by read");
	// The timeout reset turns the watchdog off, so the pulse is one cycle
	AST_RESET_PULSE: assert property (DEVICE_RESET |=> !DEVICE_RESET)
		else $error("reset pulse too long");
	AST_RETRY_UP: assert property (CE && !cfg_q.overcurrent_policy && retry_q[1] && retry_on && pwr_d[1]
		&& !dev_rst_d |=> AMP_ON[1])
		else $error("no power up in retry window");
	AST_RETRY_EXIT: assert property (CE && !cfg_q.overcurrent_policy && retry_q[1] && retry_on
		&& !OVERCURRENT_DET[1] && !dev_rst_d |=> !retry_q[1])
		else $error("retry kept after fault cleared");

	COV_EXPIRE: cover property (wd_expire);
	COV_RESET: cover property (DEVICE_RESET);
	COV_RETRY: cover property (retry_q[0] && retry_on);
	COV_FLAG_READ: cover property (flag_q ##1 !flag_q);
	COV_HOST_OFF: cover property (cfg_q.overcurrent_policy && pwr_q[0] ##1 !pwr_q[0]);
endmodule
`default_nettype wire

// ===== testbench/host_model.sv
// Host controller model: register accesses, each followed by a frame end.
// Assumes the caller enters just after a rising clock edge.
`timescale 1ns/1ns
`default_nettype none
module host_model (
	input wire logic CLK,
	input wire logic CRC_ON,
	output logic WR_EN,
	output logic RD_EN,
	output logic [6:0] ADDR,
	output logic [15:0] WDATA,
	output logic FRAME_END,
	output logic [5:0] FRAME_BITS
);
	initial begin
		{WR_EN, RD_EN, FRAME_END} = 3'h0;
		ADDR = 7'h00;
		WDATA = 16'h0000;
		FRAME_BITS = 6'h00;
	end
	// Frame length follows the CRC mode
	task automatic xfer(input logic wr, input logic [6:0] a, input logic [15:0] d);
		ADDR = a;
		WDATA = d;
		WR_EN = wr;
		RD_EN = !wr;
		@(posedge CLK);
		#1;
		{WR_EN, RD_EN} = 2'h0;
		FRAME_END = 1'b1;
		FRAME_BITS = CRC_ON ? 6'h20 : 6'h18;
		@(posedge CLK);
		#1;
		FRAME_END = 1'b0;
		// Released bus shows junk, not the old word
		WDATA = ~WDATA;
	endtask
endmodule
`default_nettype wire

// ===== testbench/analog_output_config_control_test.sv
// Self-checking bench for the configuration register block.
// Assumes shortened watchdog and retry counts set below.
`timescale 1ns/1ns
`default_nettype none
module analog_output_config_control_test;
	localparam int STEP = 20;
	localparam int RETRY = 40;
	logic clk, rstn, wr_en, rd_en, frame_end, flag_read, unmask, load_pin, ce;
	logic [6:0] addr;
	logic [15:0] wdata, rdata, d;
	logic [5:0] frame_bits;
	logic [3:0] strobe, pwr_wr, det, transp, load, cpwr, amp, ovc;
	logic pwr_we, ext_ref, crc_on, len32, wflag, dev_rst, int_n;
	logic [1:0] edge_sel;
	logic [31:0] lfsr;
	int n_errors, samples_checked, cnt;
	cfg_regs #(.STEP_CYCLES(STEP), .RETRY_CYCLES(RETRY), .RETRY_ON_CYCLES(4)) dut_u (
		.CLK(clk), .RSTN(rstn), .CE(ce), .WR_EN(wr_en), .RD_EN(rd_en), .ADDR(addr), .WDATA(wdata),
		.FRAME_END(frame_end), .FRAME_BITS(frame_bits), .WATCHDOG_FLAG_READ(flag_read),
		.WATCHDOG_FLAG_UNMASK(unmask), .DAC_LOAD_STROBE(strobe), .LOAD_PIN(load_pin),
		.CHANNEL_POWER_WR(pwr_wr), .CHANNEL_POWER_WE(pwr_we), .OVERCURRENT_DET(det), .RDATA(rdata),
		.LATCH_TRANSPARENT(transp), .LATCH_LOAD(load), .COMPARATOR_EDGE_SELECT(edge_sel),
		.EXT_REF(ext_ref), .CRC_ON(crc_on), .FRAME_LEN32(len32), .WATCHDOG_FLAG(wflag),
		.DEVICE_RESET(dev_rst), .INT_N(int_n), .CHANNEL_POWER(cpwr), .AMP_ON(amp), .OVERCURRENT_FLAG(ovc));
	host_model host_u (.CLK(clk), .CRC_ON(crc_on), .WR_EN(wr_en), .RD_EN(rd_en), .ADDR(addr),
		.WDATA(wdata), .FRAME_END(frame_end), .FRAME_BITS(frame_bits));
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [15:0] exp_cfg(input logic [15:0] v);
		return {v[15:10], 1'b0, v[8:0]};
	endfunction
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic set_pwr(input logic [3:0] v);
		pwr_wr = v;
		pwr_we = 1'b1;
		tick(1);
		pwr_we = 1'b0;
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// Hang guard
	initial begin
		#1000000;
		n_errors++;
		close_out();
	end
	initial begin
		{rstn, flag_read, load_pin, pwr_we, unmask} = 5'h00;
		ce = 1'b1;
		{strobe, pwr_wr, det} = 12'h000;
		lfsr = 32'h660d_b3ef;
		n_errors = 0;
		samples_checked = 0;
		tick(6);
		rstn = 1'b1;
		host_u.xfer(1'b0, 7'h03, 16'h0000);
		check(rdata, 16'h0001);
		check({15'h0, len32}, 16'h0001);
		$display("reset test done");
		for (int i = 0; i < 8; i++) begin
			lfsr = nxt(lfsr);
			d = {lfsr[15:12], i[1:0], lfsr[9:3], 1'b0, lfsr[1:0]};
			host_u.xfer(1'b1, 7'h03, d);
			host_u.xfer(1'b1, 7'h04, ~d);
			host_u.xfer(1'b0, 7'h03, 16'h0000);
			check(rdata, exp_cfg(d));
			check({transp, 10'h0, edge_sel}, {d[15:12], 10'h0, d[11:10]});
			check({13'h0, ext_ref, crc_on, len32}, {13'h0, d[8], d[0], d[0]});
		end
		strobe = 4'hF;
		tick(1);
		strobe = 4'h0;
		check({12'h0, load}, {12'h0, ~d[15:12]});
		$display("config test done");
		for (int a = 0; a < 2; a++) begin
			set_pwr(4'hF);
			unmask = ~a[0];
			d = {4'h5, 2'b01, 1'b1, 1'b1, 4'h1, a[0], 1'b1, 1'b0, 1'b1};
			host_u.xfer(1'b1, 7'h03, d);
			tick(2 * STEP - 6);
			check({15'h0, wflag}, 16'h0000);
			cnt = 0;
			for (int k = 0; k < 10; k++) begin
				tick(1);
				cnt += int'(dev_rst === 1'b1);
			end
			check(16'(cnt), 16'(a));
			check({14'h0, wflag, int_n}, {14'h0, 1'b1, a[0]});
			check({12'h0, cpwr}, a ? 16'h0000 : 16'h000F);
			flag_read = 1'b1;
			tick(1);
			flag_read = 1'b0;
			check({15'h0, wflag}, 16'h0000);
			host_u.xfer(1'b0, 7'h03, 16'h0000);
			check(rdata, a ? {7'h00, d[8], 7'h00, d[0]} : exp_cfg(d));
		end
		host_u.xfer(1'b1, 7'h03, 16'h0001);
		tick(3 * STEP);
		check({15'h0, wflag}, 16'h0000);
		$display("watchdog test done");
		host_u.xfer(1'b1, 7'h03, 16'h0003);
		set_pwr(4'hF);
		det = 4'h1;
		tick(3);
		det = 4'h0;
		check({8'h0, cpwr, ovc}, 16'h00E1);
		set_pwr(4'hF);
		check({12'h0, cpwr}, 16'h000F);
		host_u.xfer(1'b1, 7'h03, 16'h0001);
		det = 4'h2;
		tick(3);
		cnt = 0;
		for (int k = 0; k < 2 * RETRY; k++) begin
			tick(1);
			cnt += int'(amp[1] === 1'b1);
		end
		check({15'h0, cnt > 1 && cnt < 11}, 16'h0001);
		det = 4'h0;
		tick(RETRY + 10);
		check({12'h0, amp}, 16'h000F);
		$display("overcurrent test done");
		// Clock enable low must freeze the register against a write
		ce = 1'b0;
		host_u.xfer(1'b1, 7'h03, 16'h5555);
		ce = 1'b1;
		host_u.xfer(1'b0, 7'h03, 16'h0000);
		check(rdata, 16'h0001);
		load_pin = 1'b1;
		tick(1);
		load_pin = 1'b0;
		check({12'h0, load}, 16'h000F);
		$display("enable and pin test done");
		close_out();
	end
endmodule
`default_nettype wire
